// [src/vga_attribute_controller_regs.sv]
/*
  Attribute controller: indexed register bank behind the index/data toggle,
  palette translation, mode control effects and the status bit mux.
  Assumes one host access per cycle, strobes synchronous to clk, and a
  sequencer that presents one dot per pix.valid cycle.
*/
// Contract
// - Reading input status 1 returns the toggle to index selection.
// - Each attribute port write flips the toggle; reads leave it alone.
// - After an index write, the next write stores into the indexed register; palette entries take it only while index bit 5 is low.
// - Index register holds five selector bits and reads back.
// - Index bit 5 low blanks video for palette access; high translates normally.
// - Sixteen six-bit palette entries drive pixel bits 5 to 0.
// - Mode, border and plane registers sit at indexes 10h, 11h, 12h.
// - Mode bit 7 replaces pixel bits 5:4 with colour select bits 1:0.
// - Mode bit 6 halves the pixel clock for 256-colour width.
// - Mode bit 5 lets line compare stop panning until vertical sync.
// - Mode bit 3 picks background intensity or blink for attribute MSB.
// - Mode bit 2 makes the ninth dot copy the eighth dot for line graphics codes.
// - Mode bit 1 selects colour or monochrome adapter attributes.
// - Border register drives all eight pixel bits during overscan.
// - Plane register bits 5:4 route two pixel bits into status 1.
// - Cleared plane enable bits force pixel bits to zero before lookup.
// - Colour select bits 3:2 drive pixel bits 7:6 outside 256-colour mode.
`timescale 1ns/1ps
`default_nettype none

`include "vga_attr_consts.svh"

module vga_attribute_controller_regs
  import vga_attr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host I/O bus
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // Pixel source and timing
  input wire pix_src_t pix,
  input wire logic gfx_256,
  input wire logic blink_phase,
  input wire logic display_enable,
  input wire logic vsync,
  input wire logic line_compare,
  // Pixel outputs
  output logic [7:0] pixel_out,
  output logic pclk_en,
  // Mode outputs to other units
  output logic [3:0] pan_out,
  output logic crtc08_bits_off,
  output logic graphics_mode,
  output logic mono_attributes
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] stat_mux(input logic [1:0] sel, input logic [7:0] vd);
    case (sel)
      2'b00: stat_mux = {vd[2], vd[0]};
      2'b01: stat_mux = {vd[5], vd[4]};
      2'b10: stat_mux = {vd[3], vd[1]};
      default: stat_mux = {vd[7], vd[6]};
    endcase
  endfunction

  attr_state_t s;
  attr_state_t next_s;
  logic [5:0] pal_host;
  logic [5:0] pal_pix;
  logic [3:0] pix_index;
  logic wr_port;
  logic rd_port;
  logic stat_port;
  logic data_wr;
  logic pal_wr;
  logic dot_eff;
  logic [3:0] bg_eff;
  logic [7:0] reg_rd;

  assign wr_port = io_wr && (io_addr == `PORT_ATTR_WR);
  assign rd_port = io_rd && (io_addr == `PORT_ATTR_RD);
  assign stat_port = io_rd && ((io_addr == `PORT_STAT1_MONO) || (io_addr == `PORT_STAT1_COLOUR));
  assign data_wr = wr_port && (s.sel == SEL_DATA);
  // Palette is only writable while translation is off, so the pixel
  // lookup never sees an entry change mid-line
  assign pal_wr = data_wr && !s.index[`IDX_PAL_BIT] && !s.index[`IDX_PAS_BIT];

  // ----------------------------------------
  // Text dot formation
  // ----------------------------------------
  always_comb
  begin
    dot_eff = pix.dot;
    if (pix.ninth_dot)
    begin
      dot_eff = pix.line_gfx_code && s.mode[`MODE_LGE] && s.prev_dot;
    end
    if (s.mode[`MODE_BLINK] && pix.attr_msb && blink_phase)
    begin
      dot_eff = 1'b0;
    end
    bg_eff = s.mode[`MODE_BLINK] ? {1'b0, pix.bg[2:0]} : pix.bg;
    if (s.mode[`MODE_GFX])
    begin
      pix_index = pix.gfx_pix;
    end
    else
    begin
      pix_index = dot_eff ? pix.fg : bg_eff;
    end
    pix_index = pix_index & s.plane[3:0];
  end

  attr_palette #(
    .ENTRIES(16),
    .WIDTH(6)
  ) u_palette (
    .clk(clk),
    .nrst(nrst),
    .wr_en(pal_wr),
    .host_addr(s.index[3:0]),
    .wr_data(io_wdata[5:0]),
    .host_data(pal_host),
    .pix_addr(pix_index),
    .pix_data(pal_pix)
  );

  attr_pclk_div u_pclk (
    .clk(clk),
    .nrst(nrst),
    .dot_en(pix.valid),
    .half_rate(s.mode[`MODE_PELW]),
    .pclk_en(pclk_en)
  );

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always_comb
  begin
    reg_rd = 8'h00;
    if (!s.index[`IDX_PAL_BIT])
    begin
      reg_rd = {2'h0, pal_host};
    end
    else
    begin
      case (s.index[4:0])
        `IDX_MODE: reg_rd = s.mode;
        `IDX_BORDER: reg_rd = s.border;
        `IDX_PLANE: reg_rd = {2'h0, s.plane};
        `IDX_PAN: reg_rd = {4'h0, s.pan};
        `IDX_CSEL: reg_rd = {4'h0, s.csel};
        default: reg_rd = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rvalid = 1'b0;
    // Host writes
    if (wr_port)
    begin
      next_s.sel = (s.sel == SEL_INDEX) ? SEL_DATA : SEL_INDEX;
      if (s.sel == SEL_INDEX)
      begin
        next_s.index = 6'(io_wdata & `MASK_INDEX);
      end
      else
      begin
        case (s.index[4:0])
          `IDX_MODE: next_s.mode = io_wdata & `MASK_MODE;
          `IDX_BORDER: next_s.border = io_wdata;
          `IDX_PLANE: next_s.plane = 6'(io_wdata & `MASK_PLANE);
          `IDX_PAN: next_s.pan = 4'(io_wdata & `MASK_NIBBLE);
          `IDX_CSEL: next_s.csel = 4'(io_wdata & `MASK_NIBBLE);
          default: next_s.pan = s.pan;
        endcase
      end
    end
    // Host reads
    if (stat_port)
    begin
      next_s.sel = SEL_INDEX;
      next_s.rdata = 8'h00;
      next_s.rdata[5:4] = stat_mux(s.plane[5:4], s.pixel_out);
      next_s.rdata[`STAT_VS] = vsync;
      next_s.rdata[`STAT_DE] = ~display_enable;
      next_s.rvalid = 1'b1;
    end
    else if (io_rd && (io_addr == `PORT_ATTR_WR))
    begin
      next_s.rdata = {2'h0, s.index};
      next_s.rvalid = 1'b1;
    end
    else if (rd_port)
    begin
      next_s.rdata = (s.sel == SEL_INDEX) ? {2'h0, s.index} : reg_rd;
      next_s.rvalid = 1'b1;
    end
    // Line compare panning hold, set wins over the vsync clear
    if (vsync)
    begin
      next_s.lc_hold = 1'b0;
    end
    if (line_compare && s.mode[`MODE_PANCOMP])
    begin
      next_s.lc_hold = 1'b1;
    end
    next_s.pan_out = next_s.lc_hold ? 4'h0 : s.pan;
    // Pixel output
    if (pix.valid)
    begin
      next_s.prev_dot = dot_eff;
      if (!s.index[`IDX_PAS_BIT])
      begin
        next_s.pixel_out = 8'h00;
      end
      else if (pix.border)
      begin
        next_s.pixel_out = s.border;
      end
      else
      begin
        next_s.pixel_out[3:0] = pal_pix[3:0];
        next_s.pixel_out[5:4] = s.mode[`MODE_V54] ? s.csel[1:0] : pal_pix[5:4];
        next_s.pixel_out[7:6] = gfx_256 ? 2'b00 : s.csel[3:2];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.sel <= SEL_INDEX;
      s.plane <= `RESET_PLANE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign io_rdata = s.rdata;
  assign io_rvalid = s.rvalid;
  assign pixel_out = s.pixel_out;
  assign pan_out = s.pan_out;
  assign crtc08_bits_off = s.lc_hold;
  assign graphics_mode = s.mode[`MODE_GFX];
  assign mono_attributes = s.mode[`MODE_MONO];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_stat_clear;
    stat_port |=> (s.sel == SEL_INDEX) && io_rvalid;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status read kept toggle");

  property p_wr_flip;
    wr_port |=> s.sel != $past(s.sel);
  endproperty
  a_wr_flip: assert property (p_wr_flip) else $error("write did not flip toggle");

  property p_rd_keep;
    rd_port && !io_wr |=> $stable(s.sel);
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read moved toggle");

  property p_border_store;
    wr_port && (s.sel == SEL_DATA) && (s.index[4:0] == `IDX_BORDER) |=> s.border == $past(io_wdata);
  endproperty
  a_border_store: assert property (p_border_store) else $error("data write lost");

  property p_index_read;
    rd_port && (s.sel == SEL_INDEX) |=> io_rdata == {2'h0, $past(s.index)};
  endproperty
  a_index_read: assert property (p_index_read) else $error("index readback wrong");

  property p_blank;
    pix.valid && !s.index[`IDX_PAS_BIT] |=> pixel_out == 8'h00;
  endproperty
  a_blank: assert property (p_blank) else $error("video not blanked");

  property p_v54;
    pix.valid && s.index[`IDX_PAS_BIT] && !pix.border && s.mode[`MODE_V54]
      |=> pixel_out[5:4] == $past(s.csel[1:0]);
  endproperty
  a_v54: assert property (p_v54) else $error("colour select not substituted");

  property p_lc_hold;
    line_compare && s.mode[`MODE_PANCOMP] |=> (pan_out == 4'h0) && crtc08_bits_off;
  endproperty
  a_lc_hold: assert property (p_lc_hold) else $error("panning not held");

  property p_border_out;
    pix.valid && s.index[`IDX_PAS_BIT] && pix.border |=> pixel_out == $past(s.border);
  endproperty
  a_border_out: assert property (p_border_out) else $error("border colour wrong");

  property p_stat_mux;
    stat_port |=> io_rdata[5:4] == stat_mux($past(s.plane[5:4]), $past(s.pixel_out));
  endproperty
  a_stat_mux: assert property (p_stat_mux) else $error("status mux wrong");

endmodule

`default_nettype wire

// [src/vga_attr_consts.svh]
/*
  Offsets, field positions, masks and reset values of the attribute register bank.
  Assumes it is included by bare name ahead of the module that uses it.
*/
`ifndef VGA_ATTR_CONSTS_SVH
`define VGA_ATTR_CONSTS_SVH

// ----------------------------------------
// I/O port addresses
// ----------------------------------------
`define PORT_ATTR_WR 16'h03C0
`define PORT_ATTR_RD 16'h03C1
`define PORT_STAT1_MONO 16'h03BA
`define PORT_STAT1_COLOUR 16'h03DA

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define IDX_MODE 5'h10
`define IDX_BORDER 5'h11
`define IDX_PLANE 5'h12
`define IDX_PAN 5'h13
`define IDX_CSEL 5'h14
`define IDX_PAL_BIT 4
`define IDX_PAS_BIT 5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODE_GFX 0
`define MODE_MONO 1
`define MODE_LGE 2
`define MODE_BLINK 3
`define MODE_PANCOMP 5
`define MODE_PELW 6
`define MODE_V54 7
`define STAT_DE 0
`define STAT_VS 3

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define MASK_INDEX 8'h3F
`define MASK_MODE 8'hEF
`define MASK_PLANE 8'h3F
`define MASK_NIBBLE 8'h0F
`define RESET_BYTE 8'h00
`define RESET_PLANE 6'h0F

`endif

// [src/vga_attr_pkg.sv]
/*
  Types shared by the attribute controller files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vga_attr_pkg;

  typedef enum logic [1:0] {
    SEL_INDEX = 2'b01,
    SEL_DATA = 2'b10
  } attr_sel_t;

  // One dot as delivered by the sequencer and text logic
  typedef struct packed {
    logic valid;
    logic border;
    logic [3:0] gfx_pix;
    logic [3:0] fg;
    logic [3:0] bg;
    logic dot;
    logic attr_msb;
    logic ninth_dot;
    logic line_gfx_code;
  } pix_src_t;

  typedef struct packed {
    attr_sel_t sel;
    logic [5:0] index;
    logic [7:0] mode;
    logic [7:0] border;
    logic [5:0] plane;
    logic [3:0] pan;
    logic [3:0] csel;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] pixel_out;
    logic prev_dot;
    logic lc_hold;
    logic [3:0] pan_out;
  } attr_state_t;

  typedef struct packed {
    logic en;
    logic phase;
  } pclk_state_t;

endpackage

// [src/attr_palette.sv]
/*
  Sixteen six-bit palette entries with one host write port, one host read port
  and one pixel lookup port.
  Assumes the caller gates writes and registers both read results.
*/
`timescale 1ns/1ps
`default_nettype none

module attr_palette
  import vga_attr_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int WIDTH = 6
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host side
  input wire logic wr_en,
  input wire logic [$clog2(ENTRIES)-1:0] host_addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] host_data,
  // Pixel side
  input wire logic [$clog2(ENTRIES)-1:0] pix_addr,
  output logic [WIDTH-1:0] pix_data
);

  logic [WIDTH-1:0] entry [ENTRIES];

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        entry[i] <= '0;
      end
    end
    else if (wr_en)
    begin
      entry[host_addr] <= wr_data;
    end
  end

  assign host_data = entry[host_addr];
  assign pix_data = entry[pix_addr];

endmodule

`default_nettype wire

// [src/attr_pclk_div.sv]
/*
  Pixel clock enable: passes every dot enable, or every second one in
  wide pixel mode.
  Assumes dot_en is a one-cycle enable in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module attr_pclk_div
  import vga_attr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic dot_en,
  input wire logic half_rate,
  // Output
  output logic pclk_en
);

  pclk_state_t s;
  pclk_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.en = 1'b0;
    if (dot_en)
    begin
      next_s.phase = half_rate ? ~s.phase : 1'b0;
      next_s.en = ~half_rate | s.phase;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pclk_en = s.en;

endmodule

`default_nettype wire

// [tb/host_io.sv]
/*
  Host processor model on the I/O bus of the attribute controller.
  Assumes a rising-edge clk; the model changes the bus on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module host_io
(
  // Clock
  input wire logic clk,
  // I/O bus
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid
);
  initial
  begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end

  // Released lines show the inverse so a stale value is never taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask

  // Data is taken mid-cycle, where io_rvalid has settled high
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    io_addr = ~a;
    n = 0;
    while (io_rvalid !== 1'b1 && n < 3)
    begin
      @(negedge clk);
      n++;
    end
    d = (io_rvalid === 1'b1) ? io_rdata : 8'hXX;
  endtask
endmodule

`default_nettype wire

// [tb/vga_attribute_controller_regs_test.sv]
/*
  Self-checking bench: register bank, toggle, palette, pixel path, status mux.
  Assumes host_io drives the I/O bus; the bench drives the pixel inputs.
*/
`timescale 1ns/1ps
`default_nettype none

`include "vga_attr_consts.svh"

module vga_attribute_controller_regs_test
  import vga_attr_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic gfx_256 = 1'b0;
  logic disp_en = 1'b0;
  logic vsync = 1'b0;
  logic lc = 1'b0;
  logic pas = 1'b0;
  logic blink = 1'b0;
  logic pdot = 1'b0;
  logic [4:0] ri;
  pix_src_t tp;
  pix_src_t pix = '0;
  wire logic io_wr, io_rd, io_rvalid, pclk_en, c08, gm, mono;
  wire logic [15:0] io_addr;
  wire logic [7:0] io_wdata, io_rdata, pixel_out;
  wire logic [3:0] pan_out;
  logic [7:0] regs [32];
  logic [7:0] v;
  logic [7:0] lastpx;
  int seed = 32'hf986;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int npclk = 0;

  always #4 clk = ~clk;

  host_io host (.clk(clk), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

  vga_attribute_controller_regs dut (.clk(clk), .nrst(nrst), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .pix(pix), .gfx_256(gfx_256), .blink_phase(blink),
    .display_enable(disp_en), .vsync(vsync), .line_compare(lc),
    .pixel_out(pixel_out), .pclk_en(pclk_en), .pan_out(pan_out),
    .crtc08_bits_off(c08), .graphics_mode(gm), .mono_attributes(mono));

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [7:0] msk(input logic [4:0] i);
    if (i < 5'h10)
      return pas ? 8'h00 : 8'h3F;
    if (i == 5'h10)
      return 8'hEF;
    if (i == 5'h11)
      return 8'hFF;
    if (i == 5'h12)
      return 8'h3F;
    return (i < 5'h15) ? 8'h0F : 8'h00;
  endfunction

  function automatic logic [7:0] exp_pix(input logic [3:0] g, input logic bd);
    logic [5:0] e;
    e = regs[g & regs[18][3:0]][5:0];
    if (regs[16][7])
      e[5:4] = regs[20][1:0];
    if (!pas)
      return 8'h00;
    return bd ? regs[17] : {gfx_256 ? 2'b00 : regs[20][3:2], e};
  endfunction

  function automatic logic [7:0] exp_stat(input logic [7:0] p);
    logic [1:0] s;
    case (regs[18][5:4])
      2'b00: s = {p[2], p[0]};
      2'b01: s = {p[5], p[4]};
      2'b10: s = {p[3], p[1]};
      default: s = {p[7], p[6]};
    endcase
    return {2'b00, s, vsync, 2'b00, ~disp_en};
  endfunction

  // Dot on/off and colour index of a text dot, from the mode bits in regs[16]
  function automatic logic [4:0] txt_idx(input pix_src_t p);
    logic on;
    on = p.ninth_dot ? (p.line_gfx_code && regs[16][2] && pdot) : p.dot;
    if (regs[16][3] && p.attr_msb && blink)
      on = 1'b0;
    if (on)
      return {1'b1, p.fg};
    return {1'b0, regs[16][3] ? {1'b0, p.bg[2:0]} : p.bg};
  endfunction

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sel_idx(input logic [4:0] i);
    host.rd(`PORT_STAT1_COLOUR, v);
    host.wr(`PORT_ATTR_WR, {2'b00, pas, i});
  endtask

  task automatic setreg(input logic [4:0] i, input logic [7:0] d);
    sel_idx(i);
    host.wr(`PORT_ATTR_WR, d);
    regs[i] = (regs[i] & ~msk(i)) | (d & msk(i));
  endtask

  task automatic creg(input logic [4:0] i);
    sel_idx(i);
    host.rd(`PORT_ATTR_RD, v);
    chk("register", regs[i], v);
  endtask

  task automatic dot(input logic [3:0] g, input logic bd);
    @(negedge clk);
    pix.valid = 1'b1;
    pix.gfx_pix = g;
    pix.border = bd;
    @(negedge clk);
    pix.valid = 1'b0;
    pix.gfx_pix = ~g;
    @(negedge clk);
    lastpx = exp_pix(g, bd);
    chk("pixel_out", lastpx, pixel_out);
  endtask

  // Text dot; the ninth dot copies the previous dot as the bench saw it
  task automatic tdot(input pix_src_t p);
    logic [4:0] t;
    p.border = 1'b0;
    p.valid = 1'b1;
    t = txt_idx(p);
    @(negedge clk);
    pix = p;
    @(negedge clk);
    pix.valid = 1'b0;
    @(negedge clk);
    pdot = t[4];
    chk("text pixel_out", exp_pix(t[3:0], 1'b0), pixel_out);
  endtask

  task automatic stat();
    disp_en = 1'($random(seed));
    vsync = 1'($random(seed));
    host.rd(`PORT_STAT1_MONO, v);
    chk("status", exp_stat(lastpx), v & 8'h39);
    vsync = 1'b0;
  endtask

  // Line compare when s is 0, vertical sync when 1
  task automatic pulse(input logic s);
    @(negedge clk);
    lc = !s;
    vsync = s;
    @(negedge clk);
    lc = 1'b0;
    vsync = 1'b0;
    @(negedge clk);
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (pclk_en === 1'b1)
      npclk++;
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = (i == 18) ? 8'h0F : 8'h00;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    for (int i = 16; i < 22; i++)
      creg(5'(i));
    host.rd(`PORT_STAT1_COLOUR, v);
    host.wr(`PORT_ATTR_WR, 8'hD3);
    host.rd(`PORT_ATTR_WR, v);
    chk("index", 8'h13, v);
    $display("test reset_and_index done");
    // Reads on the read port must not move the toggle
    host.rd(`PORT_STAT1_COLOUR, v);
    host.wr(`PORT_ATTR_WR, 8'h11);
    host.rd(`PORT_ATTR_RD, v);
    host.wr(`PORT_ATTR_WR, 8'hA5);
    host.wr(`PORT_ATTR_WR, 8'h10);
    host.wr(`PORT_ATTR_WR, 8'h41);
    regs[17] = 8'hA5;
    regs[16] = 8'h41;
    creg(5'h11);
    creg(5'h10);
    $display("test toggle done");
    repeat (16)
    begin
      ri = {1'b1, 4'($random(seed))};
      setreg(ri, 8'($random(seed)));
      creg(ri);
    end
    for (int k = 0; k < 16; k++)
      setreg(5'(k), 8'($random(seed)));
    for (int k = 0; k < 16; k++)
      creg(5'(k));
    $display("test registers done");
    setreg(5'h10, 8'h03);
    @(negedge clk);
    chk("graphics_mode", 8'h01, {7'h00, gm});
    chk("mono_attributes", 8'h01, {7'h00, mono});
    pas = 1'b1;
    setreg(5'h03, 8'h2A);
    setreg(5'h10, 8'h01);
    setreg(5'h12, 8'h0F);
    @(negedge clk);
    chk("mono_attributes", 8'h00, {7'h00, mono});
    dot(4'h3, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      setreg(5'h12, 8'(k * 16 + 15));
      stat();
    end
    repeat (24)
    begin
      setreg(5'h10, 8'h01 | (8'h80 & 8'($random(seed))));
      setreg(5'h12, 8'($random(seed)));
      setreg(5'h14, 8'($random(seed)));
      setreg(5'h11, 8'($random(seed)));
      gfx_256 = 1'($random(seed));
      dot(4'($random(seed)), ($random(seed) & 3) == 0);
      stat();
    end
    pas = 1'b0;
    sel_idx(5'h10);
    dot(4'h5, 1'b0);
    pas = 1'b1;
    $display("test pixel_path done");
    for (int k = 0; k < 2; k++)
    begin
      setreg(5'h10, k ? 8'h41 : 8'h01);
      npclk = 0;
      repeat (4) dot(4'($random(seed)), 1'b0);
      repeat (2) @(negedge clk);
      chk("pclk_en count", k ? 8'h02 : 8'h04, 8'(npclk));
    end
    setreg(5'h13, 8'hF5);
    setreg(5'h10, 8'h21);
    pulse(1'b0);
    chk("pan_out", 8'h00, {4'h0, pan_out});
    chk("crtc08_bits_off", 8'h01, {7'h00, c08});
    pulse(1'b1);
    chk("pan_out", 8'h05, {4'h0, pan_out});
    setreg(5'h10, 8'h01);
    pulse(1'b0);
    chk("crtc08_bits_off", 8'h00, {7'h00, c08});
    $display("test modes done");
    // Text modes: plain, line graphics copy, blink, both
    setreg(5'h12, 8'h0F);
    for (int k = 0; k < 4; k++)
    begin
      setreg(5'h10, 8'(k * 4));
      repeat (8)
      begin
        blink = 1'($random(seed));
        tp = 18'($random(seed));
        tdot(tp);
      end
    end
    $display("test text_path done");
    report_and_stop();
  end
endmodule

`default_nettype wire
